//--- obc_pkg.sv
// constants for the option byte configuration decoder
package obc_pkg;

  // ********************************************
  // option byte selection on the programming port
  // ********************************************
  localparam logic       SEL_LOW  = 1'b0;
  localparam logic       SEL_HIGH = 1'b1;

  // ********************************************
  // programming port operations
  // ********************************************
  localparam logic [1:0] OP_READ  = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h2;

  // ********************************************
  // high byte field positions
  // ********************************************
  localparam int HI_CLK_MSB    = 7;
  localparam int HI_CLK_LSB    = 6;
  localparam int HI_RSV_ONE    = 5;
  localparam int HI_RSV_ZERO   = 4;
  localparam int HI_BOR_MSB    = 3;
  localparam int HI_BOR_LSB    = 2;
  localparam int HI_WDG_TYPE   = 1;
  localparam int HI_WDG_HALT   = 0;

  // ********************************************
  // low byte field positions
  // ********************************************
  localparam int LO_RSV_MSB    = 7;
  localparam int LO_RSV_LSB    = 4;
  localparam int LO_RSV_ZERO   = 3;
  localparam int LO_SECTOR     = 2;
  localparam int LO_READOUT    = 1;
  localparam int LO_WRPROT     = 0;

  // ********************************************
  // field encodings
  // ********************************************
  localparam logic [1:0] CLK_INTERNAL_RC = 2'h0;
  localparam logic [1:0] CLK_WAKEUP_RC   = 2'h1;
  localparam logic [1:0] CLK_RESERVED    = 2'h2;
  localparam logic [1:0] CLK_EXT_PIN     = 2'h3;
  localparam logic [1:0] BOR_LOWEST      = 2'h0;
  localparam logic [1:0] BOR_MEDIUM      = 2'h1;
  localparam logic [1:0] BOR_HIGHEST     = 2'h2;
  localparam logic [1:0] BOR_OFF         = 2'h3;

  // ********************************************
  // values after reset and erased value
  // ********************************************
  localparam logic [7:0] LOW_DEFAULT  = 8'hF0;
  localparam logic [7:0] HIGH_DEFAULT = 8'h2F;
  localparam logic [7:0] ERASED_VALUE = 8'hFF;

endpackage : obc_pkg

//--- obc_dec_if.sv
// carrier between the command engine and the option decoder
`timescale 1ns/1ns
interface obc_dec_if;
  logic [7:0] nv_low;
  logic [7:0] nv_high;
  logic [7:0] lat_low;
  logic [7:0] lat_high;
  logic [1:0] clock_sel;
  logic [1:0] bor_sel;
  logic       bor_enable;
  logic       wdg_hw_enable;
  logic       wdg_halt_reset;
  logic       sector_1k;
  logic       readout_protect;
  logic       write_protect;

  modport eng (
    output nv_low, nv_high,
    input  lat_low, lat_high, clock_sel, bor_sel, bor_enable, wdg_hw_enable,
    input  wdg_halt_reset, sector_1k, readout_protect, write_protect
  );
  modport dec (
    input  nv_low, nv_high,
    output lat_low, lat_high, clock_sel, bor_sel, bor_enable, wdg_hw_enable,
    output wdg_halt_reset, sector_1k, readout_protect, write_protect
  );
endinterface : obc_dec_if

//--- obc_decoder.sv
// latches the option bytes during reset and decodes their fields
`timescale 1ns/1ns
module obc_decoder (
  input  wire logic i_mclk,
  input  wire logic i_rst,
  obc_dec_if.dec    dif
);

  logic [7:0] low_reg;
  logic [7:0] low_next;
  logic [7:0] high_reg;
  logic [7:0] high_next;
  logic       bor_en_reg;
  logic       bor_en_next;
  logic       wdg_hw_reg;
  logic       wdg_hw_next;

  // ********************************************
  // capture while reset is held, then freeze
  // ********************************************
  always_comb begin
    low_next  = low_reg;
    high_next = high_reg;
    bor_en_next = bor_en_reg;
    wdg_hw_next = wdg_hw_reg;
    if (i_rst) begin
      low_next  = dif.nv_low;
      high_next = dif.nv_high;
      bor_en_next = (dif.nv_high[obc_pkg::HI_BOR_MSB:obc_pkg::HI_BOR_LSB] != obc_pkg::BOR_OFF);
      wdg_hw_next = ~dif.nv_high[obc_pkg::HI_WDG_TYPE];
    end
  end

  always_ff @(posedge i_mclk) begin
    low_reg    <= low_next;
    high_reg   <= high_next;
    bor_en_reg <= bor_en_next;
    wdg_hw_reg <= wdg_hw_next;
  end

  // reserved bits are carried but steer nothing
  assign dif.lat_low         = low_reg;
  assign dif.lat_high        = high_reg;
  assign dif.clock_sel       = high_reg[obc_pkg::HI_CLK_MSB:obc_pkg::HI_CLK_LSB];
  assign dif.bor_sel         = high_reg[obc_pkg::HI_BOR_MSB:obc_pkg::HI_BOR_LSB];
  assign dif.bor_enable      = bor_en_reg;
  assign dif.wdg_hw_enable   = wdg_hw_reg;
  assign dif.wdg_halt_reset  = high_reg[obc_pkg::HI_WDG_HALT];
  assign dif.sector_1k       = low_reg[obc_pkg::LO_SECTOR];
  assign dif.readout_protect = low_reg[obc_pkg::LO_READOUT];
  assign dif.write_protect   = low_reg[obc_pkg::LO_WRPROT];

endmodule : obc_decoder

//--- obc_option_config.sv
// option byte configuration: programming access, protection and decoded settings
// How it works
// - option bytes are read or written only while programming mode is active
// - high byte bits 7:6 pick start-up clock: RC, wake-up RC, reserved, pin
// - high byte bits 3:2 pick brownout threshold; 11 turns detector off
// - high byte bit 1 zero forces watchdog on; one leaves it to software
// - high byte bit 0 set: halt entry with active watchdog causes reset
// - low byte bit 2 selects first sector size: 0.5k or 1k
// - low byte bit 1 set blocks program memory read-out and flash writes
// - erasing options under read-out protection first erases whole program memory
// - low byte bit 0 set refuses every later erase or program forever
// - erased memory and erased option bytes hold FFh
`timescale 1ns/1ns
module obc_option_config (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_nv_byte_low,
  input  wire logic [7:0] i_nv_byte_high,
  input  wire logic       i_prog_mode,
  input  wire logic       i_prog_valid,
  input  wire logic [1:0] i_prog_op,
  input  wire logic       i_prog_sel,
  input  wire logic [7:0] i_prog_wdata,
  input  wire logic       i_mem_erase_done,
  input  wire logic       i_halt_entry,
  input  wire logic       i_watchdog_sw_enable,
  output logic            o_prog_ready,
  output logic            o_prog_done,
  output logic            o_prog_refused,
  output logic [7:0]      o_prog_rdata,
  output logic            o_nv_write,
  output logic            o_nv_sel,
  output logic [7:0]      o_nv_wdata,
  output logic            o_mem_erase_all,
  output logic [7:0]      o_mem_erase_value,
  output logic [1:0]      o_startup_clock_select,
  output logic [1:0]      o_brownout_threshold_select,
  output logic            o_brownout_enable,
  output logic            o_watchdog_hw_enable,
  output logic            o_watchdog_halt_reset,
  output logic            o_first_sector_size,
  output logic            o_readout_protect,
  output logic            o_permanent_write_protect,
  output logic            o_mem_read_block,
  output logic            o_mem_write_block,
  output logic            o_halt_reset
);

  typedef enum logic [2:0] {
    OBC_IDLE,
    OBC_MEM_ERASE,
    OBC_ERASE_LOW,
    OBC_ERASE_HIGH,
    OBC_FINISH
  } obc_state_t;

  obc_dec_if dif ();

  obc_decoder u_dec (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .dif    (dif)
  );

  assign dif.nv_low  = i_nv_byte_low;
  assign dif.nv_high = i_nv_byte_high;

  // ********************************************
  // command engine state
  // ********************************************
  obc_state_t state_reg;
  obc_state_t state_next;
  logic       ready_reg;
  logic       ready_next;
  logic       done_reg;
  logic       done_next;
  logic       refused_reg;
  logic       refused_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       nv_wr_reg;
  logic       nv_wr_next;
  logic       nv_sel_reg;
  logic       nv_sel_next;
  logic [7:0] nv_wdata_reg;
  logic [7:0] nv_wdata_next;
  logic       erase_all_reg;
  logic       erase_all_next;
  logic       unlocked_reg;
  logic       unlocked_next;
  logic       halt_rst_reg;
  logic       halt_rst_next;
  logic       mem_wblk_reg;
  logic       mem_wblk_next;
  logic       locked;
  logic       wdg_active;

  // read-out protection holds writes off until the options have been erased
  assign locked     = dif.readout_protect & ~unlocked_reg;
  assign wdg_active = dif.wdg_hw_enable | i_watchdog_sw_enable;

  always_comb begin
    state_next     = state_reg;
    ready_next     = 1'b0;
    done_next      = 1'b0;
    refused_next   = 1'b0;
    rdata_next     = rdata_reg;
    nv_wr_next     = 1'b0;
    nv_sel_next    = nv_sel_reg;
    nv_wdata_next  = nv_wdata_reg;
    erase_all_next = 1'b0;
    unlocked_next  = unlocked_reg;
    halt_rst_next  = i_halt_entry & wdg_active & dif.wdg_halt_reset;
    mem_wblk_next  = dif.readout_protect | dif.write_protect;
    case (state_reg)
      OBC_IDLE: begin
        ready_next = 1'b1;
        if (i_prog_valid && ready_reg) begin
          ready_next = 1'b0;
          state_next = OBC_FINISH;
          if (!i_prog_mode) begin
            refused_next = 1'b1;
          end else begin
            case (i_prog_op)
              obc_pkg::OP_READ: begin
                rdata_next = (i_prog_sel == obc_pkg::SEL_HIGH) ? i_nv_byte_high : i_nv_byte_low;
              end
              obc_pkg::OP_WRITE: begin
                if (dif.write_protect || locked) begin
                  refused_next = 1'b1;
                end else begin
                  nv_wr_next    = 1'b1;
                  nv_sel_next   = i_prog_sel;
                  nv_wdata_next = i_prog_wdata;
                end
              end
              obc_pkg::OP_ERASE: begin
                if (dif.write_protect) begin
                  refused_next = 1'b1;
                end else if (dif.readout_protect) begin
                  erase_all_next = 1'b1;
                  nv_wdata_next  = obc_pkg::ERASED_VALUE;
                  state_next     = OBC_MEM_ERASE;
                end else begin
                  state_next = OBC_ERASE_LOW;
                end
              end
              default: begin
                refused_next = 1'b1;
              end
            endcase
          end
        end
      end
      OBC_MEM_ERASE: begin
        // option bytes stay untouched until the array reports it is blank
        if (i_mem_erase_done) begin
          state_next = OBC_ERASE_LOW;
        end
      end
      OBC_ERASE_LOW: begin
        nv_wr_next    = 1'b1;
        nv_sel_next   = obc_pkg::SEL_LOW;
        nv_wdata_next = obc_pkg::ERASED_VALUE;
        state_next    = OBC_ERASE_HIGH;
      end
      OBC_ERASE_HIGH: begin
        nv_wr_next    = 1'b1;
        nv_sel_next   = obc_pkg::SEL_HIGH;
        nv_wdata_next = obc_pkg::ERASED_VALUE;
        unlocked_next = 1'b1;
        state_next    = OBC_FINISH;
      end
      OBC_FINISH: begin
        done_next  = 1'b1;
        state_next = OBC_IDLE;
      end
      default: begin
        state_next = OBC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_reg     <= OBC_IDLE;
      ready_reg     <= 1'b0;
      done_reg      <= 1'b0;
      refused_reg   <= 1'b0;
      rdata_reg     <= 8'h00;
      nv_wr_reg     <= 1'b0;
      nv_sel_reg    <= obc_pkg::SEL_LOW;
      nv_wdata_reg  <= obc_pkg::ERASED_VALUE;
      erase_all_reg <= 1'b0;
      unlocked_reg  <= 1'b0;
      halt_rst_reg  <= 1'b0;
      // memory stays write-blocked while the options are being sampled
      mem_wblk_reg  <= 1'b1;
    end else begin
      state_reg     <= state_next;
      ready_reg     <= ready_next;
      done_reg      <= done_next;
      refused_reg   <= refused_next;
      rdata_reg     <= rdata_next;
      nv_wr_reg     <= nv_wr_next;
      nv_sel_reg    <= nv_sel_next;
      nv_wdata_reg  <= nv_wdata_next;
      erase_all_reg <= erase_all_next;
      unlocked_reg  <= unlocked_next;
      halt_rst_reg  <= halt_rst_next;
      mem_wblk_reg  <= mem_wblk_next;
    end
  end

  // ********************************************
  // outputs
  // ********************************************
  // protection flags come from the reset-time copy, so a write this session
  // cannot loosen them before the next reset
  assign o_prog_ready                = ready_reg;
  assign o_prog_done                 = done_reg;
  assign o_prog_refused              = refused_reg;
  assign o_prog_rdata                = rdata_reg;
  assign o_nv_write                  = nv_wr_reg;
  assign o_nv_sel                    = nv_sel_reg;
  assign o_nv_wdata                  = nv_wdata_reg;
  assign o_mem_erase_all             = erase_all_reg;
  assign o_mem_erase_value           = nv_wdata_reg;
  assign o_startup_clock_select      = dif.clock_sel;
  assign o_brownout_threshold_select = dif.bor_sel;
  assign o_brownout_enable           = dif.bor_enable;
  assign o_watchdog_hw_enable        = dif.wdg_hw_enable;
  assign o_watchdog_halt_reset       = dif.wdg_halt_reset;
  assign o_first_sector_size         = dif.sector_1k;
  assign o_readout_protect           = dif.readout_protect;
  assign o_permanent_write_protect   = dif.write_protect;
  assign o_mem_read_block            = dif.readout_protect;
  assign o_mem_write_block           = mem_wblk_reg;
  assign o_halt_reset                = halt_rst_reg;

endmodule : obc_option_config

//--- obc_chk.sv
// port assertions for the option byte configuration decoder
`timescale 1ns/1ns
module obc_chk (
  input wire logic       i_mclk,
  input wire logic       i_rst,
  input wire logic [7:0] i_nv_byte_low,
  input wire logic [7:0] i_nv_byte_high,
  input wire logic       i_prog_mode,
  input wire logic       i_prog_valid,
  input wire logic [1:0] i_prog_op,
  input wire logic       i_halt_entry,
  input wire logic       i_watchdog_sw_enable,
  input wire logic       o_prog_ready,
  input wire logic       o_prog_refused,
  input wire logic       o_nv_write,
  input wire logic       o_mem_erase_all,
  input wire logic [1:0] o_startup_clock_select,
  input wire logic [1:0] o_brownout_threshold_select,
  input wire logic       o_brownout_enable,
  input wire logic       o_watchdog_hw_enable,
  input wire logic       o_watchdog_halt_reset,
  input wire logic       o_first_sector_size,
  input wire logic       o_readout_protect,
  input wire logic       o_permanent_write_protect,
  input wire logic       o_halt_reset
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  property p_clk; $fell(i_rst) |-> o_startup_clock_select == $past(i_nv_byte_high[7:6]); endproperty
  property p_bor; $fell(i_rst) |-> o_brownout_threshold_select == $past(i_nv_byte_high[3:2])
    && o_brownout_enable == ($past(i_nv_byte_high[3:2]) != 2'h3); endproperty
  property p_wdg; $fell(i_rst) |-> o_watchdog_hw_enable != $past(i_nv_byte_high[1]); endproperty
  property p_low; $fell(i_rst) |-> {o_first_sector_size, o_readout_protect, o_permanent_write_protect}
    == $past(i_nv_byte_low[2:0]); endproperty
  // settings only move while reset is held
  property p_hold; !$past(i_rst) |-> $stable({o_startup_clock_select, o_brownout_threshold_select,
    o_watchdog_hw_enable, o_watchdog_halt_reset, o_readout_protect}); endproperty
  property p_mode; i_prog_valid && o_prog_ready && !i_prog_mode |=> o_prog_refused && !o_nv_write; endproperty
  property p_rdp; i_prog_valid && o_prog_ready && i_prog_mode && i_prog_op == obc_pkg::OP_ERASE
    && o_readout_protect && !o_permanent_write_protect |=> o_mem_erase_all; endproperty
  property p_halt; i_halt_entry && o_watchdog_halt_reset && (o_watchdog_hw_enable || i_watchdog_sw_enable)
    |=> o_halt_reset; endproperty
  a_clk: assert property (p_clk) else $error("clock select decode");
  a_bor: assert property (p_bor) else $error("brownout decode");
  a_wdg: assert property (p_wdg) else $error("watchdog type decode");
  a_low: assert property (p_low) else $error("low byte decode");
  a_hold: assert property (p_hold) else $error("settings moved");
  a_mode: assert property (p_mode) else $error("access outside mode");
  a_rdp: assert property (p_rdp) else $error("no memory erase");
  a_halt: assert property (p_halt) else $error("no halt reset");
  c_halt: cover property (i_halt_entry ##1 o_halt_reset);
  c_erase: cover property (o_mem_erase_all);
  c_refuse: cover property (o_prog_refused);
endmodule : obc_chk
bind obc_option_config obc_chk u_chk (.i_mclk, .i_rst, .i_nv_byte_low, .i_nv_byte_high, .i_prog_mode, .i_prog_valid,
  .i_prog_op, .i_halt_entry, .i_watchdog_sw_enable, .o_prog_ready, .o_prog_refused, .o_nv_write, .o_mem_erase_all,
  .o_startup_clock_select, .o_brownout_threshold_select, .o_brownout_enable, .o_watchdog_hw_enable,
  .o_watchdog_halt_reset, .o_first_sector_size, .o_readout_protect, .o_permanent_write_protect, .o_halt_reset);

//--- obc_nv_model.sv
// far side: option byte array and program memory with slow erase
`timescale 1ns/1ns
module obc_nv_model (
  input  wire logic       i_mclk,
  input  wire logic       i_nv_write,
  input  wire logic       i_nv_sel,
  input  wire logic [7:0] i_nv_wdata,
  input  wire logic       i_mem_erase_all,
  input  wire logic [7:0] i_mem_erase_value,
  output logic      [7:0] o_nv_byte_low,
  output logic      [7:0] o_nv_byte_high,
  output logic            o_mem_erase_done,
  output logic      [7:0] o_mem_byte
);
  int cnt_reg = 0;
  logic [7:0] erase_val_reg;
  initial o_mem_erase_done = 1'b0;
  always @(posedge i_mclk) begin
    o_mem_erase_done <= (cnt_reg == 1);
    // erase takes several cycles so the wait path is exercised
    if (i_mem_erase_all) erase_val_reg <= i_mem_erase_value;
    if (i_mem_erase_all) cnt_reg <= 6;
    else if (cnt_reg > 0) cnt_reg <= cnt_reg - 1;
    if (cnt_reg == 1) o_mem_byte <= erase_val_reg;
    if (i_nv_write && i_nv_sel) o_nv_byte_high <= i_nv_wdata;
    if (i_nv_write && !i_nv_sel) o_nv_byte_low <= i_nv_wdata;
  end
  task automatic load(input logic [7:0] lo, input logic [7:0] hi);
    o_nv_byte_low = lo;
    o_nv_byte_high = hi;
    o_mem_byte = 8'h00;
  endtask : load
endmodule : obc_nv_model

//--- obc_option_config_tb_top.sv
// self-checking bench for the option byte configuration decoder
`timescale 1ns/1ns
module obc_option_config_tb_top;
  logic i_mclk, i_rst, i_prog_mode, i_prog_valid, i_prog_sel, i_mem_erase_done, i_halt_entry, i_watchdog_sw_enable;
  logic [1:0] i_prog_op, o_startup_clock_select, o_brownout_threshold_select;
  logic [7:0] i_nv_byte_low, i_nv_byte_high, i_prog_wdata, mem_byte, o_prog_rdata, o_nv_wdata, o_mem_erase_value;
  logic o_prog_ready, o_prog_done, o_prog_refused, o_nv_write, o_nv_sel, o_mem_erase_all, o_brownout_enable, rf;
  logic o_watchdog_hw_enable, o_watchdog_halt_reset, o_first_sector_size, o_readout_protect;
  logic o_permanent_write_protect, o_mem_read_block, o_mem_write_block, o_halt_reset;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  obc_option_config uut (.i_mclk, .i_rst, .i_nv_byte_low, .i_nv_byte_high, .i_prog_mode, .i_prog_valid, .i_prog_op,
    .i_prog_sel, .i_prog_wdata, .i_mem_erase_done, .i_halt_entry, .i_watchdog_sw_enable, .o_prog_ready, .o_prog_done,
    .o_prog_refused, .o_prog_rdata, .o_nv_write, .o_nv_sel, .o_nv_wdata, .o_mem_erase_all, .o_mem_erase_value,
    .o_startup_clock_select, .o_brownout_threshold_select, .o_brownout_enable, .o_watchdog_hw_enable,
    .o_watchdog_halt_reset, .o_first_sector_size, .o_readout_protect, .o_permanent_write_protect,
    .o_mem_read_block, .o_mem_write_block, .o_halt_reset);
  obc_nv_model mdl (.i_mclk, .i_nv_write(o_nv_write), .i_nv_sel(o_nv_sel), .i_nv_wdata(o_nv_wdata),
    .i_mem_erase_all(o_mem_erase_all), .i_mem_erase_value(o_mem_erase_value),
    .o_nv_byte_low(i_nv_byte_low), .o_nv_byte_high(i_nv_byte_high),
    .o_mem_erase_done(i_mem_erase_done), .o_mem_byte(mem_byte));
  // ****************
  // clock, timeout
  // ****************
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      finish_test();
    end
  end
  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic reboot(input logic [7:0] lo, input logic [7:0] hi);
    @(negedge i_mclk);
    mdl.load(lo, hi);
    i_rst = 1'b1;
    repeat (5) @(negedge i_mclk);
    i_rst = 1'b0;
    @(negedge i_mclk);
  endtask : reboot
  // request held until a cycle with ready; refused pulse caught before done
  task automatic req(input logic [1:0] op, input logic sel, input logic [7:0] wd);
    int n;
    rf = 1'b0;
    i_prog_valid = 1'b1;
    i_prog_op = op;
    i_prog_sel = sel;
    i_prog_wdata = wd;
    for (n = 0; n < 50 && o_prog_ready !== 1'b1; n++) @(negedge i_mclk);
    @(negedge i_mclk);
    i_prog_valid = 1'b0;
    for (n = 0; n < 200 && o_prog_done !== 1'b1; n++) begin
      if (o_prog_refused === 1'b1) rf = 1'b1;
      @(negedge i_mclk);
    end
    chk(o_prog_done, 8'h01, "done");
  endtask : req
  task automatic t_decode;
    logic [7:0] hi;
    for (int i = 0; i < 4; i++) begin
      hi = {i[1:0], 2'b10, i[1:0], i[0], i[1]};
      reboot({4'hF, 1'b0, i[0], i[1], 1'b0}, hi);
      chk(o_startup_clock_select, i[1:0], "clock");
      chk(o_brownout_threshold_select, i[1:0], "bor");
      chk(o_brownout_enable, i != 3, "bor on");
      chk(o_watchdog_hw_enable, !i[0], "hw wdg");
      chk(o_first_sector_size, i[0], "sector");
      chk(o_mem_read_block, i[1], "read block");
      chk(o_readout_protect, i[1], "readout flag");
      chk(o_watchdog_halt_reset, i[1], "halt option");
      chk(o_prog_ready, 1'b1, "ready after reset");
      i_watchdog_sw_enable = (i == 3);
      i_halt_entry = 1'b1;
      @(negedge i_mclk);
      i_halt_entry = 1'b0;
      chk(o_halt_reset, i[1], "halt reset");
    end
    $display("test decode done");
  endtask : t_decode
  task automatic t_hold;
    reboot(8'hF0, 8'h2F);
    req(obc_pkg::OP_WRITE, obc_pkg::SEL_HIGH, 8'hE3);
    req(obc_pkg::OP_READ, obc_pkg::SEL_HIGH, 8'h00);
    chk(o_prog_rdata, 8'hE3, "read back");
    chk(o_startup_clock_select, 2'h0, "clock kept");
    i_prog_mode = 1'b0;
    req(obc_pkg::OP_READ, obc_pkg::SEL_LOW, 8'h00);
    chk(rf, 1'b1, "mode off");
    i_prog_mode = 1'b1;
    req(2'h3, obc_pkg::SEL_LOW, 8'h00);
    chk(rf, 1'b1, "bad op");
    req(obc_pkg::OP_ERASE, obc_pkg::SEL_LOW, 8'h00);
    chk(i_nv_byte_high, 8'hFF, "erased");
    reboot(i_nv_byte_low, i_nv_byte_high);
    chk(o_startup_clock_select, 2'h3, "clock new");
    $display("test hold done");
  endtask : t_hold
  task automatic t_readout;
    reboot(8'hF6, 8'h2F);
    req(obc_pkg::OP_WRITE, obc_pkg::SEL_LOW, 8'hF4);
    chk(rf, 1'b1, "locked write");
    chk(o_mem_write_block, 1'b1, "write block");
    req(obc_pkg::OP_ERASE, obc_pkg::SEL_LOW, 8'h00);
    chk(mem_byte, 8'hFF, "memory erased");
    chk(i_nv_byte_low, 8'hFF, "option erased");
    req(obc_pkg::OP_WRITE, obc_pkg::SEL_LOW, 8'hF0);
    chk(rf, 1'b0, "unlocked");
    $display("test readout done");
  endtask : t_readout
  task automatic t_wp;
    reboot(8'hF1, 8'h2F);
    req(obc_pkg::OP_WRITE, obc_pkg::SEL_LOW, 8'hF0);
    chk(rf, 1'b1, "wp write");
    req(obc_pkg::OP_ERASE, obc_pkg::SEL_LOW, 8'h00);
    chk(rf, 1'b1, "wp erase");
    chk(i_nv_byte_low, 8'hF1, "wp kept");
    chk(o_permanent_write_protect, 1'b1, "wp flag");
    chk(o_mem_write_block, 1'b1, "wp block");
    $display("test protect done");
  endtask : t_wp
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    i_rst = 1'b1;
    i_prog_mode = 1'b1;
    i_prog_valid = 1'b0;
    i_prog_op = 2'h0;
    i_prog_sel = 1'b0;
    i_prog_wdata = 8'h00;
    i_halt_entry = 1'b0;
    i_watchdog_sw_enable = 1'b0;
    t_decode();
    t_hold();
    t_readout();
    t_wp();
    finish_test();
  end
endmodule : obc_option_config_tb_top
